// [src/rtca_pkg.sv]
// Package with register map, field layouts and timing constants of the core
package rtca_pkg;

	// ****************************************************************
	// Widths and timing
	// ****************************************************************
	localparam int RTCA_AW           = 8;
	localparam int RTCA_DW           = 8;
	localparam int RTCA_MEM_AW       = 7;
	localparam int RTCA_MEM_WORDS    = 128;
	localparam int RTCA_OSC_HZ       = 32768;
	localparam int RTCA_DIV_W        = 15;
	localparam int RTCA_CLK_MHZ      = 200;
	localparam int RTCA_PULSE_MS     = 250;
	localparam int RTCA_PULSE_CYCLES = RTCA_PULSE_MS * RTCA_CLK_MHZ * 1000;
	localparam int RTCA_PULSE_W      = 26;
	localparam int RTCA_LEVELS       = 6;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] RTCA_REG_SEC    = 8'h00;
	localparam logic [7:0] RTCA_REG_MIN    = 8'h01;
	localparam logic [7:0] RTCA_REG_HOUR   = 8'h02;
	localparam logic [7:0] RTCA_REG_DATE   = 8'h03;
	localparam logic [7:0] RTCA_REG_MONTH  = 8'h04;
	localparam logic [7:0] RTCA_REG_YEAR   = 8'h05;
	localparam logic [7:0] RTCA_REG_WDAY   = 8'h06;
	localparam logic [7:0] RTCA_REG_STATUS = 8'h07;
	localparam logic [7:0] RTCA_REG_CTRL   = 8'h08;
	localparam logic [7:0] RTCA_REG_FOUT   = 8'h09;
	localparam logic [7:0] RTCA_REG_BROWN  = 8'h0A;
	localparam logic [7:0] RTCA_REG_BATT   = 8'h0B;
	localparam logic [7:0] RTCA_REG_ALM0   = 8'h10;
	localparam logic [7:0] RTCA_REG_ALM5   = 8'h15;
	localparam logic [7:0] RTCA_REG_DST0   = 8'h20;
	localparam logic [7:0] RTCA_REG_DST5   = 8'h25;
	localparam logic [7:0] RTCA_MEM_BASE   = 8'h80;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int RTCA_ST_ALARM   = 0;
	localparam int RTCA_ST_BROWN   = 1;
	localparam int RTCA_ST_FROZEN  = 2;
	localparam int RTCA_ST_SUMMER  = 3;
	localparam int RTCA_CT_ALM_EN  = 0;
	localparam int RTCA_CT_REPEAT  = 1;
	localparam int RTCA_CT_AUTOCLR = 2;
	localparam int RTCA_CT_SUMMER  = 3;
	localparam int RTCA_CT_IRQ_EN  = 4;
	localparam int RTCA_ALM_EN_BIT = 7;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] date;
		logic [2:0] wday;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} rtca_time_t;

	// Enables in order sec, min, hour, date, month, wday
	typedef struct packed {
		logic [5:0] en;
		rtca_time_t val;
	} rtca_alarm_t;

	typedef struct packed {
		logic [3:0] month;
		logic [4:0] date;
		logic [4:0] hour;
	} rtca_dst_point_t;

	localparam rtca_time_t RTCA_TIME_RST = '{year: 7'h00, month: 4'h1,
		date: 5'h01, wday: 3'h0, hour: 5'h00, min: 6'h00, sec: 6'h00};
	localparam logic [7:0] RTCA_CTRL_RST = 8'h00;
	localparam logic [2:0] RTCA_LEVEL_RST = 3'h0;

	// Years 00..99 stand for 2000..2099, so every fourth year is leap
	function automatic logic [4:0] rtca_month_days(input logic [3:0] m,
		input logic [6:0] y);
		logic [4:0] d;
		d = 5'h1F;
		if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) begin
			d = 5'h1E;
		end else if (m == 4'h2) begin
			d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
		end
		return d;
	endfunction : rtca_month_days

endpackage : rtca_pkg

// [src/rtca_mem.sv]
// User memory with a registered read port shared by the register read path
module rtca_mem
	import rtca_pkg::*;
(
	input  wire logic                       clk_i,
	input  wire logic                       rstn_i,
	input  wire logic                       we_i,
	input  wire logic                       mem_sel_i,
	input  wire logic [rtca_pkg::RTCA_MEM_AW-1:0] addr_i,
	input  wire logic [rtca_pkg::RTCA_DW-1:0]     wdata_i,
	input  wire logic                       rd_i,
	input  wire logic [rtca_pkg::RTCA_DW-1:0]     reg_data_i,
	output logic      [rtca_pkg::RTCA_DW-1:0]     rdata_o
);
	import rtca_pkg::*;

	// No reset on the array: contents survive while the core keeps power
	logic [RTCA_DW-1:0] mem [RTCA_MEM_WORDS];

	always_ff @(posedge clk_i) begin
		if (we_i && mem_sel_i) begin
			mem[addr_i] <= wdata_i;
		end
	end

	// Read data stand only in the cycle after the read
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i && mem_sel_i) begin
			rdata_o <= mem[addr_i];
		end else if (rd_i) begin
			rdata_o <= reg_data_i;
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule : rtca_mem

// [src/rtca_core.sv]
// Clock, calendar, alarm, supply monitor and frequency output core
// Functional notes
// - Separate counters for seconds, minutes, hours, date, month, year, weekday.
// - Calendar correct through 2099 with automatic leap day.
// - Summer time shift applied automatically from host start and end points.
// - Alarm fires when clock matches programmed comparison value while frequency output is off.
// - Match sets pollable alarm flag, or drives interrupt pin if enabled.
// - Repeating mode re-triggers on every recurring match.
// - Interrupt pin is open drain, active low, signals alarm.
// - Outside repeating mode, interrupt stays low until the alarm flag is cleared.
// - With auto clear, reading status clears flag and, outside repeating mode, releases interrupt.
// - Backup supply warnings below 85% and 75% kept in monitor register.
// - Brown-out trip point chosen from six levels.
// - Low supply reset pin pulled low while main supply below trip.
// - On backup supply the serial bus is ignored.
// - Serial data pin only pulls low or releases.
// - Frequency output open drain, rate and enable set by host.
// - 128 bytes user memory kept on backup supply.
// - Timebase from crystal or external 32.768kHz clock at oscillator input.
// - Repeating mode pulls interrupt low 250ms and sets flag.
// - Brown-out flag clears when host reads it while main supply is above trip.
// - After total power loss clock frozen until a clock register write.
module rtca_core
	import rtca_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = rtca_pkg::RTCA_PULSE_CYCLES
) (
	input  wire logic                          clk_i,
	input  wire logic                          rstn_i,
	input  wire logic [rtca_pkg::RTCA_AW-1:0]  addr_i,
	input  wire logic [rtca_pkg::RTCA_DW-1:0]  wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	output logic      [rtca_pkg::RTCA_DW-1:0]  rdata_o,
	input  wire logic                          osc_in_i,
	input  wire logic                          on_backup_i,
	input  wire logic [rtca_pkg::RTCA_LEVELS-1:0] supply_below_i,
	input  wire logic                          backup_below_85_i,
	input  wire logic                          backup_below_75_i,
	input  wire logic                          sda_pull_i,
	output logic                               sda_o,
	output logic                               sda_oe_o,
	output logic                               irq_oe_o,
	output logic                               fout_oe_o,
	output logic                               low_supply_reset_oe_o
);
	import rtca_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	rtca_time_t             now;
	rtca_time_t             next_now;
	rtca_alarm_t            alarm;
	rtca_dst_point_t        dst_start;
	rtca_dst_point_t        dst_end;
	logic                   summer_active;
	logic                   next_summer;
	logic                   running;
	logic [7:0]             ctrl;
	logic [3:0]             fout_sel;
	logic [2:0]             level;
	logic [1:0]             backup_level_monitor;
	logic                   alarm_flag;
	logic                   brownout_flag;
	logic                   osc_q;
	logic [RTCA_DIV_W-1:0]  div;
	logic                   tick_q;
	logic [RTCA_PULSE_W-1:0] pulse_cnt;
	logic [RTCA_DW-1:0]     reg_data;

	// ****************************************************************
	// Bus gating and decode
	// ****************************************************************
	logic wr;
	logic rd;
	logic time_wr;
	logic status_rd;
	logic osc_edge;
	logic sec_tick;
	logic below_trip;
	logic alarm_match;
	logic alarm_fire;
	logic fout_on;
	logic [2:0] lvl_sel;

	assign wr        = wr_i && !on_backup_i;
	assign rd        = rd_i && !on_backup_i;
	assign time_wr   = wr && (addr_i <= RTCA_REG_WDAY);
	assign status_rd = rd && (addr_i == RTCA_REG_STATUS);

	// ****************************************************************
	// Timebase
	// ****************************************************************
	// Edges of the oscillator input; crystal or direct drive look alike
	assign osc_edge = osc_in_i && !osc_q;
	// A clock register write in the tick cycle wins; that second is then not counted
	assign sec_tick = osc_edge && (div == '1) && running && !time_wr;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			osc_q <= 1'b0;
		end else begin
			osc_q <= osc_in_i;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div <= '0;
		end else if (wr && addr_i == RTCA_REG_SEC) begin
			div <= '0;
		end else if (osc_edge) begin
			div <= div + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= sec_tick;
		end
	end

	// ****************************************************************
	// Calendar increment
	// ****************************************************************
	always_comb begin
		next_now    = now;
		next_summer = summer_active;
		if (sec_tick) begin
			if (now.sec == 6'd59) begin
				next_now.sec = 6'd0;
				if (now.min == 6'd59) begin
					next_now.min = 6'd0;
					next_now.hour = (now.hour == 5'd23) ? 5'd0 :
						now.hour + 5'd1;
					if (ctrl[RTCA_CT_SUMMER] && !summer_active &&
						now.month == dst_start.month &&
						now.date == dst_start.date &&
						next_now.hour == dst_start.hour) begin
						next_now.hour = next_now.hour + 5'd1;
						next_summer = 1'b1;
					end else if (ctrl[RTCA_CT_SUMMER] && summer_active &&
						now.month == dst_end.month &&
						now.date == dst_end.date &&
						next_now.hour == dst_end.hour) begin
						next_now.hour = now.hour;
						next_summer = 1'b0;
					end
					if (now.hour == 5'd23 && next_now.hour == 5'd0) begin
						next_now.wday = (now.wday == 3'd6) ? 3'd0 :
							now.wday + 3'd1;
						if (now.date == rtca_month_days(now.month,
							now.year)) begin
							next_now.date = 5'd1;
							if (now.month == 4'd12) begin
								next_now.month = 4'd1;
								next_now.year = (now.year == 7'd99) ?
									7'd0 : now.year + 7'd1;
							end else begin
								next_now.month = now.month + 4'd1;
							end
						end else begin
							next_now.date = now.date + 5'd1;
						end
					end
				end else begin
					next_now.min = now.min + 6'd1;
				end
			end else begin
				next_now.sec = now.sec + 6'd1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			now <= RTCA_TIME_RST;
		end else if (time_wr) begin
			if (addr_i == RTCA_REG_SEC) begin
				now.sec <= wdata_i[5:0];
			end else if (addr_i == RTCA_REG_MIN) begin
				now.min <= wdata_i[5:0];
			end else if (addr_i == RTCA_REG_HOUR) begin
				now.hour <= wdata_i[4:0];
			end else if (addr_i == RTCA_REG_DATE) begin
				now.date <= wdata_i[4:0];
			end else if (addr_i == RTCA_REG_MONTH) begin
				now.month <= wdata_i[3:0];
			end else if (addr_i == RTCA_REG_YEAR) begin
				now.year <= wdata_i[6:0];
			end else begin
				now.wday <= wdata_i[2:0];
			end
		end else begin
			now <= next_now;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			summer_active <= 1'b0;
		end else if (!ctrl[RTCA_CT_SUMMER]) begin
			summer_active <= 1'b0;
		end else begin
			summer_active <= next_summer;
		end
	end

	// Reset stands for loss of both supplies
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			running <= 1'b0;
		end else if (time_wr) begin
			running <= 1'b1;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl <= RTCA_CTRL_RST;
		end else if (wr && addr_i == RTCA_REG_CTRL) begin
			ctrl <= wdata_i;
		end else if (alarm_fire && !ctrl[RTCA_CT_REPEAT]) begin
			// Single event: disarm after one match
			ctrl[RTCA_CT_ALM_EN] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fout_sel <= 4'h0;
			level    <= RTCA_LEVEL_RST;
		end else if (wr && addr_i == RTCA_REG_FOUT) begin
			fout_sel <= wdata_i[3:0];
		end else if (wr && addr_i == RTCA_REG_BROWN) begin
			level <= wdata_i[2:0];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alarm <= '0;
		end else if (wr && addr_i == RTCA_REG_ALM0) begin
			alarm.en[0] <= wdata_i[RTCA_ALM_EN_BIT];
			alarm.val.sec <= wdata_i[5:0];
		end else if (wr && addr_i == RTCA_REG_ALM0 + 8'h01) begin
			alarm.en[1] <= wdata_i[RTCA_ALM_EN_BIT];
			alarm.val.min <= wdata_i[5:0];
		end else if (wr && addr_i == RTCA_REG_ALM0 + 8'h02) begin
			alarm.en[2] <= wdata_i[RTCA_ALM_EN_BIT];
			alarm.val.hour <= wdata_i[4:0];
		end else if (wr && addr_i == RTCA_REG_ALM0 + 8'h03) begin
			alarm.en[3] <= wdata_i[RTCA_ALM_EN_BIT];
			alarm.val.date <= wdata_i[4:0];
		end else if (wr && addr_i == RTCA_REG_ALM0 + 8'h04) begin
			alarm.en[4] <= wdata_i[RTCA_ALM_EN_BIT];
			alarm.val.month <= wdata_i[3:0];
		end else if (wr && addr_i == RTCA_REG_ALM5) begin
			alarm.en[5] <= wdata_i[RTCA_ALM_EN_BIT];
			alarm.val.wday <= wdata_i[2:0];
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dst_start <= '0;
			dst_end   <= '0;
		end else if (wr && addr_i == RTCA_REG_DST0) begin
			dst_start.month <= wdata_i[3:0];
		end else if (wr && addr_i == RTCA_REG_DST0 + 8'h01) begin
			dst_start.date <= wdata_i[4:0];
		end else if (wr && addr_i == RTCA_REG_DST0 + 8'h02) begin
			dst_start.hour <= wdata_i[4:0];
		end else if (wr && addr_i == RTCA_REG_DST0 + 8'h03) begin
			dst_end.month <= wdata_i[3:0];
		end else if (wr && addr_i == RTCA_REG_DST0 + 8'h04) begin
			dst_end.date <= wdata_i[4:0];
		end else if (wr && addr_i == RTCA_REG_DST5) begin
			dst_end.hour <= wdata_i[4:0];
		end
	end

	// ****************************************************************
	// Alarm
	// ****************************************************************
	assign fout_on = (fout_sel != 4'h0);
	assign alarm_match =
		(!alarm.en[0] || now.sec == alarm.val.sec) &&
		(!alarm.en[1] || now.min == alarm.val.min) &&
		(!alarm.en[2] || now.hour == alarm.val.hour) &&
		(!alarm.en[3] || now.date == alarm.val.date) &&
		(!alarm.en[4] || now.month == alarm.val.month) &&
		(!alarm.en[5] || now.wday == alarm.val.wday);
	// Checked once per second, the cycle after the counters moved
	assign alarm_fire = tick_q && ctrl[RTCA_CT_ALM_EN] && !fout_on &&
		alarm_match;

	// Set wins over clear in the same cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alarm_flag <= 1'b0;
		end else if (alarm_fire) begin
			alarm_flag <= 1'b1;
		end else if (status_rd && ctrl[RTCA_CT_AUTOCLR]) begin
			alarm_flag <= 1'b0;
		end else if (wr && addr_i == RTCA_REG_STATUS &&
			wdata_i[RTCA_ST_ALARM]) begin
			alarm_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pulse_cnt <= '0;
		end else if (alarm_fire && ctrl[RTCA_CT_REPEAT]) begin
			pulse_cnt <= RTCA_PULSE_W'(PULSE_CYCLES);
		end else if (pulse_cnt != '0) begin
			pulse_cnt <= pulse_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_oe_o <= 1'b0;
		end else if (!ctrl[RTCA_CT_IRQ_EN]) begin
			irq_oe_o <= 1'b0;
		end else if (ctrl[RTCA_CT_REPEAT]) begin
			irq_oe_o <= (pulse_cnt != '0);
		end else begin
			irq_oe_o <= alarm_flag;
		end
	end

	// ****************************************************************
	// Supply monitors
	// ****************************************************************
	// Codes above the sixth level fall back to the highest one
	assign lvl_sel = (level > 3'd5) ? 3'd5 : level;
	assign below_trip = supply_below_i[lvl_sel];

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			brownout_flag <= 1'b0;
		end else if (below_trip) begin
			brownout_flag <= 1'b1;
		end else if (status_rd) begin
			brownout_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			low_supply_reset_oe_o <= 1'b0;
		end else begin
			low_supply_reset_oe_o <= below_trip;
		end
	end

	genvar gi;
	for (gi = 0; gi < 2; gi++) begin : g_batt
		logic below;
		assign below = (gi == 0) ? backup_below_85_i : backup_below_75_i;
		always_ff @(posedge clk_i or negedge rstn_i) begin
			if (!rstn_i) begin
				backup_level_monitor[gi] <= 1'b0;
			end else if (below) begin
				backup_level_monitor[gi] <= 1'b1;
			end else if (wr && addr_i == RTCA_REG_BATT && wdata_i[gi]) begin
				backup_level_monitor[gi] <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Pins
	// ****************************************************************
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fout_oe_o <= 1'b0;
			sda_o     <= 1'b0;
			sda_oe_o  <= 1'b0;
		end else begin
			fout_oe_o <= fout_on && !div[fout_sel - 4'h1];
			sda_o     <= 1'b0;
			sda_oe_o  <= sda_pull_i && !on_backup_i;
		end
	end

	// ****************************************************************
	// Read mux
	// ****************************************************************
	always_comb begin
		reg_data = 8'h00;
		if (addr_i == RTCA_REG_SEC) begin
			reg_data = {2'b00, now.sec};
		end else if (addr_i == RTCA_REG_MIN) begin
			reg_data = {2'b00, now.min};
		end else if (addr_i == RTCA_REG_HOUR) begin
			reg_data = {3'b000, now.hour};
		end else if (addr_i == RTCA_REG_DATE) begin
			reg_data = {3'b000, now.date};
		end else if (addr_i == RTCA_REG_MONTH) begin
			reg_data = {4'h0, now.month};
		end else if (addr_i == RTCA_REG_YEAR) begin
			reg_data = {1'b0, now.year};
		end else if (addr_i == RTCA_REG_WDAY) begin
			reg_data = {5'h00, now.wday};
		end else if (addr_i == RTCA_REG_STATUS) begin
			reg_data = {4'h0, summer_active, !running, brownout_flag,
				alarm_flag};
		end else if (addr_i == RTCA_REG_CTRL) begin
			reg_data = ctrl;
		end else if (addr_i == RTCA_REG_FOUT) begin
			reg_data = {4'h0, fout_sel};
		end else if (addr_i == RTCA_REG_BROWN) begin
			reg_data = {5'h00, level};
		end else if (addr_i == RTCA_REG_BATT) begin
			reg_data = {6'h00, backup_level_monitor};
		end else if (addr_i == RTCA_REG_ALM0) begin
			reg_data = {alarm.en[0], 1'b0, alarm.val.sec};
		end else if (addr_i == RTCA_REG_ALM0 + 8'h01) begin
			reg_data = {alarm.en[1], 1'b0, alarm.val.min};
		end else if (addr_i == RTCA_REG_ALM0 + 8'h02) begin
			reg_data = {alarm.en[2], 2'b00, alarm.val.hour};
		end else if (addr_i == RTCA_REG_ALM0 + 8'h03) begin
			reg_data = {alarm.en[3], 2'b00, alarm.val.date};
		end else if (addr_i == RTCA_REG_ALM0 + 8'h04) begin
			reg_data = {alarm.en[4], 3'b000, alarm.val.month};
		end else if (addr_i == RTCA_REG_ALM5) begin
			reg_data = {alarm.en[5], 4'h0, alarm.val.wday};
		end else if (addr_i == RTCA_REG_DST0) begin
			reg_data = {4'h0, dst_start.month};
		end else if (addr_i == RTCA_REG_DST0 + 8'h01) begin
			reg_data = {3'b000, dst_start.date};
		end else if (addr_i == RTCA_REG_DST0 + 8'h02) begin
			reg_data = {3'b000, dst_start.hour};
		end else if (addr_i == RTCA_REG_DST0 + 8'h03) begin
			reg_data = {4'h0, dst_end.month};
		end else if (addr_i == RTCA_REG_DST0 + 8'h04) begin
			reg_data = {3'b000, dst_end.date};
		end else if (addr_i == RTCA_REG_DST5) begin
			reg_data = {3'b000, dst_end.hour};
		end
	end

	rtca_mem u_mem (
		.clk_i      (clk_i),
		.rstn_i     (rstn_i),
		.we_i       (wr),
		.mem_sel_i  (addr_i[7]),
		.addr_i     (addr_i[RTCA_MEM_AW-1:0]),
		.wdata_i    (wdata_i),
		.rd_i       (rd),
		.reg_data_i (reg_data),
		.rdata_o    (rdata_o)
	);

endmodule : rtca_core

// [bench/rtca_core_properties.sv]
// Port-level checks of the clock core
module rtca_chk
	import rtca_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = 20
) (
	input wire logic                 clk_i,
	input wire logic                 rstn_i,
	input wire logic [rtca_pkg::RTCA_AW-1:0]     addr_i,
	input wire logic [rtca_pkg::RTCA_DW-1:0]     wdata_i,
	input wire logic                 wr_i,
	input wire logic                 rd_i,
	input wire logic [rtca_pkg::RTCA_DW-1:0]     rdata_o,
	input wire logic                 on_backup_i,
	input wire logic [rtca_pkg::RTCA_LEVELS-1:0] supply_below_i,
	input wire logic                 sda_pull_i,
	input wire logic                 sda_o,
	input wire logic                 sda_oe_o,
	input wire logic                 low_supply_reset_oe_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	sequence mem_wr;
		wr_i && addr_i[7] && !on_backup_i;
	endsequence
	sequence mem_rd;
		rd_i && !on_backup_i && addr_i == $past(addr_i, 2);
	endsequence
	sequence st_rd;
		rd_i && addr_i == RTCA_REG_STATUS && supply_below_i == '0;
	endsequence
	chk_mem_keep: assert property (
		mem_wr ##1 !wr_i ##1 mem_rd |=> rdata_o == $past(wdata_i, 3))
		else $error("memory read differs from write");
	chk_brown_clr: assert property (
		st_rd ##1 st_rd |=> !rdata_o[RTCA_ST_BROWN])
		else $error("brownout flag survived a read");
	chk_bkp_read: assert property (
		rd_i && on_backup_i |=> rdata_o == 8'h00)
		else $error("read answered on backup");
	chk_bkp_sda: assert property (on_backup_i |=> !sda_oe_o)
		else $error("data line pulled on backup");
	chk_sda_track: assert property (
		$past(rstn_i) |-> sda_oe_o == $past(sda_pull_i && !on_backup_i))
		else $error("data line enable wrong");
	chk_sda_low: assert property (!sda_o)
		else $error("data line driven high");
	chk_lsr_idle: assert property (
		supply_below_i == '0 |=> !low_supply_reset_oe_o)
		else $error("reset pin low without brownout");
	chk_lsr_trip: assert property (
		supply_below_i == '1 |=> low_supply_reset_oe_o)
		else $error("reset pin released in brownout");
endmodule : rtca_chk

bind rtca_core rtca_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_rtca_chk (
	.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .on_backup_i(on_backup_i),
	.supply_below_i(supply_below_i), .sda_pull_i(sda_pull_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .low_supply_reset_oe_o(low_supply_reset_oe_o));

// [bench/rtca_host.sv]
// Host side of the two-wire data line
module rtca_host (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic sda_oe_i,
	output logic      sda_pull_o,
	output logic      sda_line_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] cnt;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 3'h0;
		end else begin
			cnt <= cnt + 3'h1;
		end
	end
	assign sda_pull_o = cnt[1];
	// Pull-up wins unless the device sinks the line
	assign sda_line_o = ~sda_oe_i;
endmodule : rtca_host

// [bench/testbench.sv]
// Self-checking bench of the clock core
module testbench import rtca_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, osc = 0, bkp = 0;
	logic       b85 = 0, b75 = 0, pull, line, irq, lsr, sda_oe, fo;
	logic [7:0] addr_i = '0, wdata_i = '0, rdata_o;
	logic [5:0] below = '0;
	logic [7:0] tv [7] = '{8'h3B, 8'h3B, 8'h17, 8'h1C, 8'h02, 8'h04, 8'h03};
	logic [7:0] ev [7] = '{8'h00, 8'h00, 8'h00, 8'h1D, 8'h02, 8'h04, 8'h04};
	int         fails = 0, cmp_count = 0;
	rtca_core #(.PULSE_CYCLES(20)) i_rtca_core (.clk_i(clk_i), .rstn_i(rstn_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .osc_in_i(osc), .on_backup_i(bkp),
		.supply_below_i(below), .backup_below_85_i(b85),
		.backup_below_75_i(b75), .sda_pull_i(pull), .sda_o(),
		.sda_oe_o(sda_oe), .irq_oe_o(irq), .fout_oe_o(fo),
		.low_supply_reset_oe_o(lsr));
	rtca_host i_rtca_host (.clk_i(clk_i), .rstn_i(rstn_i), .sda_oe_i(sda_oe),
		.sda_pull_o(pull), .sda_line_o(line));
	always #2.5 clk_i = ~clk_i;
	task automatic chk(input string n, input logic [7:0] v, e);
		cmp_count++;
		if (v !== e) begin
			$display("unexpected %s exp %h got %h", n, e, v);
			fails++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
		@(posedge clk_i) wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk_i) {rd_i, addr_i} <= {1'b1, a};
		@(posedge clk_i) rd_i <= 1'b0;
		#1 chk("rdata", rdata_o, e);
	endtask : rd
	task automatic tb(input int n);
		repeat (n) begin
			@(posedge clk_i) osc <= 1'b1;
			@(posedge clk_i) osc <= 1'b0;
		end
	endtask : tb
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	initial begin
		#400_000;
		fails++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		tb(3);
		rd(RTCA_REG_STATUS, 8'h04);
		rd(RTCA_REG_SEC, 8'h00);
		$display("test frozen done");
		for (int k = 0; k < RTCA_LEVELS; k++) begin
			wr(RTCA_REG_BROWN, 8'(k));
			@(posedge clk_i) below <= ~(6'h01 << k);
			repeat (2) @(posedge clk_i);
			#1 chk("lsr", {7'h00, lsr}, 8'h00);
			@(posedge clk_i) below <= 6'h01 << k;
			repeat (2) @(posedge clk_i);
			#1 chk("lsr", {7'h00, lsr}, 8'h01);
		end
		@(posedge clk_i) below <= 6'h3F;
		repeat (2) @(posedge clk_i);
		#1 chk("lsr", {7'h00, lsr}, 8'h01);
		rd(RTCA_REG_STATUS, 8'h06);
		// Two status reads back to back
		@(posedge clk_i) {below, rd_i, addr_i} <= {6'h00, 1'b1, RTCA_REG_STATUS};
		@(posedge clk_i) #1 chk("status", rdata_o, 8'h06);
		@(posedge clk_i) rd_i <= 1'b0;
		#1 chk("status", rdata_o, 8'h04);
		rd(RTCA_REG_STATUS, 8'h04);
		$display("test brownout done");
		@(posedge clk_i) b85 <= 1'b1;
		rd(RTCA_REG_BATT, 8'h01);
		@(posedge clk_i) b75 <= 1'b1;
		rd(RTCA_REG_BATT, 8'h03);
		@(posedge clk_i) {b85, b75} <= 2'b00;
		wr(RTCA_REG_BATT, 8'h03);
		rd(RTCA_REG_BATT, 8'h00);
		$display("test battery done");
		wr(8'h80, 8'hA5);
		rd(8'h80, 8'hA5);
		wr(8'hFF, 8'h5A);
		rd(8'hFF, 8'h5A);
		@(posedge clk_i) bkp <= 1'b1;
		wr(8'h80, 8'h00);
		rd(8'h80, 8'h00);
		chk("sda", {7'h00, line}, 8'h01);
		@(posedge clk_i) bkp <= 1'b0;
		rd(8'h80, 8'hA5);
		rd(8'h0C, 8'h00);
		$display("test memory done");
		wr(RTCA_REG_ALM0, 8'h80);
		wr(RTCA_REG_CTRL, 8'h15);
		for (int i = 0; i < 7; i++) wr(8'(i), tv[i]);
		tb(32767);
		rd(RTCA_REG_SEC, 8'h3B);
		chk("irq", {7'h00, irq}, 8'h00);
		tb(1);
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 7; i++) rd(8'(i), ev[i]);
		chk("irq", {7'h00, irq}, 8'h01);
		rd(RTCA_REG_STATUS, 8'h01);
		repeat (2) @(posedge clk_i);
		#1 chk("irq", {7'h00, irq}, 8'h00);
		rd(RTCA_REG_STATUS, 8'h00);
		$display("test alarm done");
		wr(RTCA_REG_FOUT, 8'h01);
		repeat (2) @(posedge clk_i);
		#1 chk("fout", {7'h00, fo}, 8'h01);
		tb(1);
		repeat (2) @(posedge clk_i);
		#1 chk("fout", {7'h00, fo}, 8'h00);
		$display("test fout done");
		end_of_test();
	end
endmodule : testbench
